// ### src/tlic_top.sv
// top-level interrupt aggregation, de-assertion interval and pin driver
//
// Register access over APB was chosen for this implementation.
module tlic_top (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// event sources
	input wire tlic_pkg::tlic_pm_s pm_flag,
	input wire tlic_pkg::tlic_pm_s pm_flag_en,
	input wire tlic_pkg::tlic_timer_s timer_in,
	input wire logic dev_ready,
	input wire logic xtal_clk,
	// interrupt pin
	output logic irq_pin_o,
	output logic irq_pin_oe
);
	import tlic_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] deas;
		logic irq_en;
		logic pol;
		logic clk_sel;
		logic buf_type;
		logic sts_sw;
		logic sts_ready;
		logic sts_tmr;
		logic en_sw;
		logic en_ready;
		logic en_tmr;
		logic en_pwr;
		tlic_pin_e fsm;
		logic [7:0] cnt;
		logic [PRE_W-1:0] pre;
		logic [15:0] tprev;
		logic rdy_prev;
		logic xs1;
		logic xs2;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic pin_o;
		logic pin_oe;
	} tlic_state_s;

	tlic_state_s q;
	tlic_state_s d;
	logic pwr_sts;
	logic master;
	logic wr_done;
	logic deas_clr;
	logic pin_req;
	logic act;
	logic lvl;
	logic [31:0] cfg_word;
	logic [31:0] ev_word;
	logic [31:0] en_word;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic is_mapped(input logic [11:0] a);
		is_mapped = (a == OFS_PIN_CFG) || (a == OFS_STATUS) || (a == OFS_ENABLE);
	endfunction : is_mapped

	function automatic logic [31:0] ev_pack(input logic sw, input logic rdy,
			input logic tmr, input logic pwr);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[EV_SW_BIT] = sw;
		w[EV_READY_BIT] = rdy;
		w[EV_TIMER_BIT] = tmr;
		w[EV_POWER_BIT] = pwr;
		ev_pack = w;
	endfunction : ev_pack

	// ----------------------------------------
	// combined line
	// ----------------------------------------
	// power status level
	assign pwr_sts = |({pm_flag.energy, pm_flag.wol} & {pm_flag_en.energy, pm_flag_en.wol});
	assign master = (pwr_sts & q.en_pwr) | (q.sts_tmr & q.en_tmr & timer_in.enable)
		| q.sts_sw | (q.sts_ready & q.en_ready);

	assign ev_word = ev_pack(q.sts_sw, q.sts_ready, q.sts_tmr, pwr_sts);
	assign en_word = ev_pack(q.en_sw, q.en_ready, q.en_tmr, q.en_pwr);

	always_comb begin
		cfg_word = 32'h0000_0000;
		cfg_word[CFG_DEAS_LSB +: 8] = q.deas;
		cfg_word[CFG_HOLD_BIT] = (q.fsm == ST_HOLD);
		cfg_word[CFG_MASTER_BIT] = master;
		cfg_word[CFG_OE_BIT] = q.irq_en;
		cfg_word[CFG_POL_BIT] = q.pol;
		cfg_word[CFG_CLKSEL_BIT] = q.clk_sel;
		cfg_word[CFG_TYPE_BIT] = q.buf_type;
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		d = q;
		wr_done = psel & penable & q.pready & pwrite & ~q.pslverr;
		deas_clr = 1'b0;
		// one wait state so read data comes from a flop
		d.pready = psel & penable & ~q.pready;
		// error flag stands only beside pready
		d.pslverr = 1'b0;
		if (psel && penable && !q.pready) begin
			d.pslverr = ~is_mapped(paddr);
			unique case (paddr)
				OFS_PIN_CFG: d.prdata = cfg_word;
				OFS_STATUS: d.prdata = ev_word;
				OFS_ENABLE: d.prdata = en_word;
				default: d.prdata = 32'h0000_0000;
			endcase
		end
		if (wr_done && paddr == OFS_PIN_CFG) begin
			d.deas = pwdata[CFG_DEAS_LSB +: 8];
			d.irq_en = pwdata[CFG_OE_BIT];
			d.pol = pwdata[CFG_POL_BIT];
			d.clk_sel = pwdata[CFG_CLKSEL_BIT];
			d.buf_type = pwdata[CFG_TYPE_BIT];
			deas_clr = pwdata[CFG_CLR_BIT];
		end
		if (wr_done && paddr == OFS_STATUS) begin
			if (pwdata[EV_SW_BIT])
				d.sts_sw = 1'b0;
			if (pwdata[EV_READY_BIT])
				d.sts_ready = 1'b0;
			if (pwdata[EV_TIMER_BIT])
				d.sts_tmr = 1'b0;
		end
		if (wr_done && paddr == OFS_ENABLE) begin
			d.en_sw = pwdata[EV_SW_BIT];
			d.en_ready = pwdata[EV_READY_BIT];
			d.en_tmr = pwdata[EV_TIMER_BIT];
			d.en_pwr = pwdata[EV_POWER_BIT];
		end
		// sets after clears: an event never loses to a clear
		// rising edge of enable
		if (d.en_sw && !q.en_sw)
			d.sts_sw = 1'b1;
		d.rdy_prev = dev_ready;
		if (dev_ready && !q.rdy_prev)
			d.sts_ready = 1'b1;
		d.tprev = timer_in.count;
		if (q.tprev == 16'h0000 && timer_in.count == TIMER_WRAP)
			d.sts_tmr = 1'b1;

		pin_req = d.irq_en & master;
		unique case (q.fsm)
			ST_IDLE: begin
				if (pin_req)
					d.fsm = ST_ASSERT;
			end
			ST_ASSERT: begin
				if (!pin_req)
					d.fsm = (d.deas != 8'h00) ? ST_HOLD : ST_IDLE;
			end
			ST_HOLD: begin
				if (q.pre == PRE_W'(TICK_CYC - 1)) begin
					d.pre = '0;
					d.cnt = q.cnt + 8'h01;
					if (d.cnt >= d.deas)
						d.fsm = ST_IDLE;
				end else begin
					d.pre = q.pre + PRE_W'(1);
				end
			end
		endcase
		if (q.fsm != ST_HOLD || d.fsm != ST_HOLD) begin
			d.cnt = 8'h00;
			d.pre = '0;
		end
		if (deas_clr && d.deas != 8'h00) begin
			d.fsm = ST_HOLD;
			d.cnt = 8'h00;
			d.pre = '0;
		end
		if (d.deas == 8'h00 && d.fsm == ST_HOLD) begin
			d.fsm = pin_req ? ST_ASSERT : ST_IDLE;
			d.cnt = 8'h00;
			d.pre = '0;
		end

		// pin driver; crystal clock is only seen at half pclk at best
		d.xs1 = xtal_clk;
		d.xs2 = q.xs1;
		act = (d.fsm == ST_ASSERT);
		lvl = d.clk_sel ? q.xs2 : act;
		if (d.buf_type) begin
			d.pin_oe = 1'b1;
			d.pin_o = ~(d.pol ^ lvl);
		end else begin
			d.pin_oe = lvl;
			d.pin_o = 1'b0;
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
			q.deas <= DEAS_RESET;
			q.fsm <= ST_IDLE;
		end else begin
			q <= d;
		end
	end

	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign irq_pin_o = q.pin_o;
	assign irq_pin_oe = q.pin_oe;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	property p_wrap;
		@(posedge pclk) disable iff (!presetn)
		q.tprev == 16'h0000 && timer_in.count == TIMER_WRAP |=> q.sts_tmr;
	endproperty
	a_wrap: assert property (p_wrap) else $error("timer wrap not flagged");

	property p_w1c;
		@(posedge pclk) disable iff (!presetn)
		wr_done && paddr == OFS_STATUS && pwdata[EV_TIMER_BIT]
		&& !(q.tprev == 16'h0000 && timer_in.count == TIMER_WRAP) |=> !q.sts_tmr;
	endproperty
	a_w1c: assert property (p_w1c) else $error("timer status not cleared");

	property p_swedge;
		@(posedge pclk) disable iff (!presetn)
		$rose(q.en_sw) |-> q.sts_sw;
	endproperty
	a_swedge: assert property (p_swedge) else $error("software edge missed");

	property p_pinoff;
		@(posedge pclk) disable iff (!presetn)
		!q.irq_en |-> q.fsm != ST_ASSERT;
	endproperty
	a_pinoff: assert property (p_pinoff) else $error("pin asserted while disabled");

	property p_withheld;
		@(posedge pclk) disable iff (!presetn)
		q.fsm == ST_HOLD |=> q.fsm != ST_ASSERT || q.deas == 8'h00;
	endproperty
	a_withheld: assert property (p_withheld) else $error("interrupt leaked in interval");

	property p_zero;
		@(posedge pclk) disable iff (!presetn)
		q.deas == 8'h00 |-> q.fsm != ST_HOLD;
	endproperty
	a_zero: assert property (p_zero) else $error("interval with zero length");

	property p_start;
		@(posedge pclk) disable iff (!presetn)
		$past(q.fsm) == ST_ASSERT && q.fsm != ST_ASSERT && q.deas != 8'h00 |-> q.fsm == ST_HOLD;
	endproperty
	a_start: assert property (p_start) else $error("interval did not start");

	property p_tick;
		@(posedge pclk) disable iff (!presetn)
		q.fsm == ST_HOLD && q.pre != PRE_W'(TICK_CYC - 1) && !wr_done |=> q.cnt == $past(q.cnt);
	endproperty
	a_tick: assert property (p_tick) else $error("count moved between ticks");

	property p_od;
		@(posedge pclk) disable iff (!presetn)
		!q.buf_type |-> !q.pin_o && (q.pin_oe == (q.clk_sel ? $past(q.xs2) : q.fsm == ST_ASSERT));
	endproperty
	a_od: assert property (p_od) else $error("open-drain drive wrong");

	property p_pp;
		@(posedge pclk) disable iff (!presetn)
		q.buf_type && !q.clk_sel |-> q.pin_oe && q.pin_o == (q.pol ~^ (q.fsm == ST_ASSERT));
	endproperty
	a_pp: assert property (p_pp) else $error("push-pull level wrong");

	property p_apb;
		@(posedge pclk) disable iff (!presetn)
		psel && penable && !q.pready |=> q.pready ##1 !q.pready;
	endproperty
	a_apb: assert property (p_apb) else $error("apb answer timing wrong");

	property p_ready;
		@(posedge pclk) disable iff (!presetn)
		dev_ready && !q.rdy_prev |=> q.sts_ready;
	endproperty
	a_ready: assert property (p_ready) else $error("ready status not set");

	property p_err;
		@(posedge pclk) disable iff (!presetn)
		psel && penable && !q.pready && !is_mapped(paddr) |=> q.pready && q.pslverr;
	endproperty
	a_err: assert property (p_err) else $error("unmapped access not refused");

	property p_errlen;
		@(posedge pclk) disable iff (!presetn)
		!q.pready |-> !q.pslverr;
	endproperty
	a_errlen: assert property (p_errlen) else $error("error flag outside answer");

	property p_release;
		@(posedge pclk) disable iff (!presetn)
		q.fsm == ST_HOLD && q.pre == PRE_W'(TICK_CYC - 1) && q.cnt + 8'h01 >= q.deas && !wr_done |=> q.fsm != ST_HOLD;
	endproperty
	a_release: assert property (p_release) else $error("interval overran its count");

	property p_clkpin;
		@(posedge pclk) disable iff (!presetn)
		q.clk_sel && q.buf_type |-> q.pin_oe && q.pin_o == (q.pol ~^ $past(q.xs2));
	endproperty
	a_clkpin: assert property (p_clkpin) else $error("debug clock not on pin");

	property p_clr;
		@(posedge pclk) disable iff (!presetn)
		wr_done && paddr == OFS_PIN_CFG && pwdata[CFG_CLR_BIT]
		&& pwdata[CFG_DEAS_LSB +: 8] != 8'h00 |=> q.fsm == ST_HOLD && q.cnt == 8'h00;
	endproperty
	a_clr: assert property (p_clr) else $error("interval clear did not restart");

	property p_swpin;
		@(posedge pclk) disable iff (!presetn)
		q.sts_sw && q.irq_en && q.fsm == ST_IDLE && !wr_done |=> q.fsm == ST_ASSERT;
	endproperty
	a_swpin: assert property (p_swpin) else $error("software event not driven");
endmodule : tlic_top

// ### src/tlic_pkg.sv
// constants and carrier types of the top-level interrupt controller
package tlic_pkg;
	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [11:0] OFS_PIN_CFG = 12'h054;
	localparam logic [11:0] OFS_STATUS = 12'h058;
	localparam logic [11:0] OFS_ENABLE = 12'h05C;
	// ----------------------------------------
	// pin configuration fields
	// ----------------------------------------
	localparam int CFG_DEAS_LSB = 24;
	localparam int CFG_CLR_BIT = 14;
	localparam int CFG_HOLD_BIT = 13;
	localparam int CFG_MASTER_BIT = 12;
	localparam int CFG_OE_BIT = 8;
	localparam int CFG_POL_BIT = 4;
	localparam int CFG_CLKSEL_BIT = 1;
	localparam int CFG_TYPE_BIT = 0;
	// ----------------------------------------
	// status and enable fields (same positions)
	// ----------------------------------------
	localparam int EV_SW_BIT = 31;
	localparam int EV_READY_BIT = 30;
	localparam int EV_TIMER_BIT = 19;
	localparam int EV_POWER_BIT = 17;
	// ----------------------------------------
	// reset values and timing
	// ----------------------------------------
	localparam logic [7:0] DEAS_RESET = 8'h00;
	localparam logic [15:0] TIMER_WRAP = 16'hFFFF;
	localparam int TICK_US = 10;
	localparam int CLK_MHZ = 10;
	localparam int TICK_CYC = TICK_US * CLK_MHZ;
	localparam int PRE_W = $clog2(TICK_CYC);
	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {ST_IDLE, ST_ASSERT, ST_HOLD} tlic_pin_e;
	typedef struct packed {
		logic [1:0] energy;
		logic [1:0] wol;
	} tlic_pm_s;
	typedef struct packed {
		logic [15:0] count;
		logic enable;
	} tlic_timer_s;
endpackage : tlic_pkg

// ### sim/tlic_host.sv
// host-side receiver model of the interrupt pin
module tlic_host (
	// pin from the device
	input wire logic irq_pin_o,
	input wire logic irq_pin_oe,
	// active level host software expects
	input wire logic act_hi,
	// resolved wire and request seen
	output logic irq_wire,
	output logic irq_seen
);
	timeunit 1ns;
	timeprecision 1ns;
	assign irq_wire = irq_pin_oe ? irq_pin_o : 1'b1;
	assign irq_seen = (irq_wire == act_hi);
endmodule : tlic_host

// ### sim/testbench.sv
// self-checking bench of the interrupt controller
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import tlic_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic pready, pslverr, er, irq_pin_o, irq_pin_oe, irq_wire, irq_seen, last;
	logic dev_ready = 1, xtal_clk = 0, act_hi = 0;
	tlic_pm_s pm_flag = '0, pm_flag_en = '0;
	tlic_timer_s timer_in = '0;
	int error_cnt = 0, check_count = 0;
	always #50 pclk = ~pclk;
	tlic_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pm_flag(pm_flag), .pm_flag_en(pm_flag_en), .timer_in(timer_in), .dev_ready(dev_ready),
		.xtal_clk(xtal_clk), .irq_pin_o(irq_pin_o), .irq_pin_oe(irq_pin_oe));
	tlic_host host (.irq_pin_o(irq_pin_o), .irq_pin_oe(irq_pin_oe), .act_hi(act_hi),
		.irq_wire(irq_wire), .irq_seen(irq_seen));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task results;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : results
	task chk32(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %0t word %h expected %h", $time, g, e);
		end
	endtask : chk32
	task chk1(input logic g, input logic e);
		check_count++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %0t flag %b expected %b", $time, g, e);
		end
	endtask : chk1
	task cyc(input int k);
		repeat (k) @(posedge pclk);
	endtask : cyc
	// request held until pready is seen at an edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		if (n >= 20) begin
			error_cnt++;
			results();
		end
	endtask : apb
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1, a, d);
	endtask : wr
	task retrig;
		wr(OFS_ENABLE, 32'h0);
		wr(OFS_ENABLE, 32'h8000_0000);
	endtask : retrig
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		cyc(5);
		presetn <= 1;
		cyc(2);
		apb(0, OFS_PIN_CFG, 0); chk32(rd, 32'h0);
		apb(0, OFS_STATUS, 0); chk32(rd, 32'h4000_0000);
		apb(0, OFS_ENABLE, 0); chk32(rd, 32'h0);
		apb(0, 12'h060, 0); chk1(er, 1'b1);
		$display("test reset done");
		wr(OFS_ENABLE, 32'h4000_0000);
		cyc(3); chk1(irq_seen, 1'b0);
		apb(0, OFS_PIN_CFG, 0); chk32(rd, 32'h1000);
		wr(OFS_PIN_CFG, 32'h100);
		cyc(3); chk1(irq_seen, 1'b1);
		wr(OFS_STATUS, 32'h4000_0000);
		cyc(3); chk1(irq_seen, 1'b0);
		wr(OFS_ENABLE, 32'h8000_0000);
		cyc(3); chk1(irq_seen, 1'b1);
		wr(OFS_STATUS, 32'h8000_0000);
		apb(0, OFS_STATUS, 0); chk32(rd, 32'h0);
		$display("test ready and software done");
		wr(OFS_ENABLE, 32'h8_0000);
		timer_in <= '{16'h0000, 1'b0};
		cyc(1);
		timer_in <= '{16'hFFFF, 1'b0};
		cyc(3); chk1(irq_seen, 1'b0);
		apb(0, OFS_STATUS, 0); chk32(rd, 32'h8_0000);
		wr(OFS_STATUS, 32'h0);
		apb(0, OFS_STATUS, 0); chk32(rd, 32'h8_0000);
		wr(OFS_STATUS, 32'h8_0000);
		timer_in <= '{16'h0000, 1'b1};
		cyc(1);
		timer_in <= '{16'hFFFF, 1'b1};
		cyc(3); chk1(irq_seen, 1'b1);
		wr(OFS_STATUS, 32'h8_0000);
		apb(0, OFS_STATUS, 0); chk32(rd, 32'h0);
		$display("test timer done");
		wr(OFS_ENABLE, 32'h2_0000);
		pm_flag <= tlic_pm_s'(4'h1);
		cyc(3);
		apb(0, OFS_STATUS, 0); chk32(rd, 32'h0);
		for (int i = 0; i < 4; i++) begin
			pm_flag <= tlic_pm_s'(4'h1 << i);
			pm_flag_en <= tlic_pm_s'(4'h1 << i);
			cyc(3);
			apb(0, OFS_STATUS, 0); chk32(rd, 32'h2_0000);
			chk1(irq_seen, 1'b1);
		end
		pm_flag <= '0;
		$display("test power done");
		wr(OFS_PIN_CFG, 32'h0100_0100);
		retrig();
		wr(OFS_STATUS, 32'h8000_0000);
		retrig();
		cyc(3); chk1(irq_seen, 1'b0);
		apb(0, OFS_PIN_CFG, 0); chk32(rd, 32'h0100_3100);
		cyc(60); chk1(irq_seen, 1'b0);
		cyc(40); chk1(irq_seen, 1'b1);
		wr(OFS_PIN_CFG, 32'h0100_4100);
		cyc(3); chk1(irq_seen, 1'b0);
		wr(OFS_PIN_CFG, 32'h100);
		cyc(3); chk1(irq_seen, 1'b1);
		wr(OFS_PIN_CFG, 32'h0200_0100);
		wr(OFS_STATUS, 32'h8000_0000);
		retrig();
		cyc(150); chk1(irq_seen, 1'b0);
		cyc(80); chk1(irq_seen, 1'b1);
		$display("test interval done");
		act_hi <= 1;
		wr(OFS_PIN_CFG, 32'h111);
		cyc(3); chk1(irq_wire, 1'b1);
		wr(OFS_PIN_CFG, 32'h110);
		cyc(3); chk1(irq_wire, 1'b0);
		// push-pull while the clock is shown
		wr(OFS_PIN_CFG, 32'h113);
		cyc(3);
		last = irq_wire;
		for (int i = 0; i < 6; i++) begin
			xtal_clk <= ~xtal_clk;
			cyc(5); chk1(irq_wire, ~last);
			last = irq_wire;
		end
		$display("test pin modes done");
		results();
	end
endmodule : testbench
